// ### hw/nvtk_pkg.sv
// Constants, types and register layout of the timekeeping RAM host port.
// Assumes a single 40 MHz clock; every slower rate comes from dividers.
package nvtk_pkg;

  // Clock rate and documented times in their own units
  localparam int CLK_HZ = 40000000;
  localparam int SEC_DIV = 16; // Sixteenth-second base tick
  localparam int RHOLD_US = 500; // Least read-bit low time
  localparam int RST_HOLD_MS = 40; // Least power-on reset stretch
  localparam int SIXT_CYCLES = CLK_HZ / SEC_DIV;
  localparam int RHOLD_CYCLES = (CLK_HZ / 1000000) * RHOLD_US;
  localparam int RST_HOLD_CYCLES = (CLK_HZ / 1000) * RST_HOLD_MS;

  // Memory geometry
  localparam int ADDR_W = 15;
  localparam int DATA_W = 8;
  localparam int MEM_WORDS = 32768;
  localparam logic [14:0] TOP_BASE = 15'h7FF0; // Sixteen clock bytes

  // Clock register indices within the top sixteen bytes
  localparam logic [3:0] IDX_FLAGS = 4'h0;
  localparam logic [3:0] IDX_ALM_SEC = 4'h2;
  localparam logic [3:0] IDX_ALM_MIN = 4'h3;
  localparam logic [3:0] IDX_ALM_HOUR = 4'h4;
  localparam logic [3:0] IDX_ALM_DATE = 4'h5;
  localparam logic [3:0] IDX_INTR = 4'h6;
  localparam logic [3:0] IDX_WDOG = 4'h7;
  localparam logic [3:0] IDX_CTRL = 4'h8;
  localparam logic [3:0] IDX_SEC = 4'h9;
  localparam logic [3:0] IDX_MIN = 4'hA;
  localparam logic [3:0] IDX_HOUR = 4'hB;
  localparam logic [3:0] IDX_DAY = 4'hC;
  localparam logic [3:0] IDX_DATE = 4'hD;
  localparam logic [3:0] IDX_MONTH = 4'hE;
  localparam logic [3:0] IDX_YEAR = 4'hF;

  // Field positions
  localparam int CTRL_WHOLD = 7;
  localparam int CTRL_RHOLD = 6;
  localparam int SEC_OSC_OFF = 7;
  localparam int INTR_AE = 7;
  localparam int INTR_ABE = 5;
  localparam int WDOG_STEER = 7;
  localparam int ALM_MASK = 7;

  // Values after reset: oscillator stopped, day, date and month at one, everything else cleared
  localparam logic [7:0] SEC_RESET = 8'h80;
  localparam logic [7:0] BYTE_RESET = 8'h00;

  // Host pins as seen after synchronisation
  typedef struct packed {
    logic cs_n;
    logic oe_n;
    logic we_n;
    logic pwr_ok;
    logic [14:0] addr;
    logic [7:0] din;
  } nvtk_pins_t;

  // One full BCD timekeeping set
  typedef struct packed {
    logic [7:0] cent;
    logic [7:0] year;
    logic [7:0] month;
    logic [7:0] date;
    logic [7:0] day;
    logic [7:0] hour;
    logic [7:0] min;
    logic [7:0] sec;
  } nvtk_time_t;

endpackage

// ### hw/nvtk_host_port.sv
// Bytewide host port of a 32k x 8 timekeeping RAM with clock, alarm,
// watchdog and power-on reset. Assumes host pins are asynchronous to mclk
// and are synchronised here; power state arrives as a comparator level.
`timescale 1ns/10ps
`default_nettype none

module nvtk_host_port
  import nvtk_pkg::*;
#(
  parameter int SIXT_CNT = SIXT_CYCLES, // Cycles per 1/16 second
  parameter int RHOLD_CNT = RHOLD_CYCLES, // Read-bit settle cycles
  parameter int RST_CNT = RST_HOLD_CYCLES // Reset stretch cycles
) (
  input wire logic mclk, // 40 MHz clock
  input wire logic resetn, // Synchronous reset, active low
  input wire logic chip_sel_n, // Chip select pin
  input wire logic out_en_n, // Output enable pin
  input wire logic write_n, // Write strobe pin
  input wire logic [14:0] address_lines, // Address pins
  input wire logic [7:0] data_lines_in, // Data pins, sensed level
  input wire logic supply_ok, // Supply above power_fail_level
  output logic [7:0] data_lines_out, // Data pins, driven value
  output logic data_lines_oe, // Data pins driven when high
  output logic alarm_wake_out_n, // Interrupt pin value, always low
  output logic alarm_wake_oe, // Interrupt pin pulled low when high
  output logic reset_out_n, // Reset pin value, always low
  output logic reset_oe // Reset pin pulled low when high
);

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  nvtk_pins_t pins_raw; // Raw pin bundle
  nvtk_pins_t pins_s1; // First stage, read only by second
  nvtk_pins_t pins_s; // Second stage, safe to use

  assign pins_raw = '{cs_n: chip_sel_n, oe_n: out_en_n, we_n: write_n,
                      pwr_ok: supply_ok, addr: address_lines,
                      din: data_lines_in};

  // Two flops per pin; address skew settles before the write end
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      pins_s1 <= '{cs_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, default: '0};
      pins_s <= '{cs_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, default: '0};
    end else begin
      pins_s1 <= pins_raw;
      pins_s <= pins_s1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Storage

  logic [7:0] mem [0:MEM_WORDS-1]; // Plain RAM bytes
  logic [7:0] ext_reg [0:15]; // Host-visible clock bytes
  nvtk_time_t int_reg; // Internal counting set
  logic af_reg; // Alarm flag
  logic wf_reg; // Watchdog flag

  // Access gating and bus decode
  logic top_sel; // Address in the clock bytes
  logic wr_act; // Write in progress
  logic wr_prev_reg; // Write active last cycle
  logic wr_end; // One-cycle pulse at end of write
  logic [14:0] waddr_reg; // Address captured at write start
  logic [7:0] wdata_reg; // Last data seen while writing
  logic rd_act; // Read mode, selected
  logic rd_prev_reg; // Read mode last cycle
  logic [7:0] top_rd; // Read value of a clock byte

  assign top_sel = (pins_s.addr >= TOP_BASE);
  // Deselected below the power-fail level
  assign wr_act = pins_s.pwr_ok & !pins_s.cs_n & !pins_s.we_n;
  assign rd_act = pins_s.pwr_ok & !pins_s.cs_n & pins_s.we_n;
  // A write cut short by power loss is dropped, not committed
  assign wr_end = wr_prev_reg & !wr_act & pins_s.pwr_ok;

  ////////////////////////////////////////////////////////////////////////
  // Write cycle capture

  // Address latched at the later falling edge, data until the end
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      wr_prev_reg <= 1'b0;
      rd_prev_reg <= 1'b0;
      waddr_reg <= '0;
      wdata_reg <= '0;
    end else begin
      wr_prev_reg <= wr_act;
      rd_prev_reg <= rd_act;
      if (wr_act && !wr_prev_reg) begin
        waddr_reg <= pins_s.addr;
      end
      if (wr_act) begin
        wdata_reg <= pins_s.din;
      end
    end
  end

  // Plain RAM bytes; no reset so contents survive everything
  always_ff @(posedge mclk) begin
    if (wr_end && waddr_reg < TOP_BASE) begin
      mem[waddr_reg] <= wdata_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read path

  // Flags byte assembled, battery-low always reads zero
  always_comb begin
    if (pins_s.addr[3:0] == IDX_FLAGS) begin
      top_rd = {wf_reg, af_reg, 6'h00};
    end else begin
      top_rd = ext_reg[pins_s.addr[3:0]];
    end
  end

  // Data follows the address every cycle, no strobe needed
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      data_lines_out <= 8'h00;
    end else if (top_sel) begin
      data_lines_out <= top_rd;
    end else begin
      data_lines_out <= mem[pins_s.addr];
    end
  end

  // Drivers on only in read mode with both enables; write overrides
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      data_lines_oe <= 1'b0;
    end else begin
      data_lines_oe <= rd_act & !pins_s.oe_n;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Timebase divider

  logic [21:0] div_cnt_reg; // Cycle counter within 1/16 s
  logic [3:0] sixt_cnt_reg; // Sixteenths within a second
  logic sixt_tick; // 1/16 s enable pulse
  logic sec_tick; // 1 s enable pulse
  logic osc_run; // Oscillator enabled

  assign sixt_tick = (div_cnt_reg == 22'(SIXT_CNT - 1));
  assign sec_tick = sixt_tick && (sixt_cnt_reg == 4'hF);
  assign osc_run = !ext_reg[IDX_SEC][SEC_OSC_OFF];

  // Free-running divider; the only slow rate in the block
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      div_cnt_reg <= '0;
      sixt_cnt_reg <= '0;
    end else if (sixt_tick) begin
      div_cnt_reg <= '0;
      sixt_cnt_reg <= sixt_cnt_reg + 4'h1;
    end else begin
      div_cnt_reg <= div_cnt_reg + 22'h000001;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Internal clock/calendar

  // BCD increment by one
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    if (v[3:0] == 4'h9) begin
      bcd_inc = {v[7:4] + 4'h1, 4'h0};
    end else begin
      bcd_inc = {v[7:4], v[3:0] + 4'h1};
    end
  endfunction

  // Last date of the month; leap every fourth year through 2099
  function automatic logic [7:0] month_end(input logic [7:0] mo,
                                           input logic [7:0] yr);
    logic leap;
    leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
                 : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 ||
                    yr[3:0] == 4'h8);
    if (mo == 8'h02) begin
      month_end = leap ? 8'h29 : 8'h28;
    end else if (mo == 8'h04 || mo == 8'h06 || mo == 8'h09 ||
                 mo == 8'h11) begin
      month_end = 8'h30;
    end else begin
      month_end = 8'h31;
    end
  endfunction

  logic whold_prev_reg; // Write bit last cycle
  logic whold_fall; // Write bit just cleared
  nvtk_time_t ext_time; // External set viewed as a time
  nvtk_time_t int_next; // Internal set one second on

  assign whold_fall = whold_prev_reg & !ext_reg[IDX_CTRL][CTRL_WHOLD];
  assign ext_time = '{cent: {2'b00, ext_reg[IDX_CTRL][5:0]},
                      year: ext_reg[IDX_YEAR], month: ext_reg[IDX_MONTH],
                      date: ext_reg[IDX_DATE], day: ext_reg[IDX_DAY],
                      hour: ext_reg[IDX_HOUR], min: ext_reg[IDX_MIN],
                      sec: {1'b0, ext_reg[IDX_SEC][6:0]}};

  // Carry chain of one second, all fields in BCD
  always_comb begin
    int_next = int_reg;
    if (int_reg.sec != 8'h59) begin
      int_next.sec = bcd_inc(int_reg.sec);
    end else begin
      int_next.sec = 8'h00;
      if (int_reg.min != 8'h59) begin
        int_next.min = bcd_inc(int_reg.min);
      end else begin
        int_next.min = 8'h00;
        if (int_reg.hour != 8'h23) begin
          int_next.hour = bcd_inc(int_reg.hour);
        end else begin
          int_next.hour = 8'h00;
          int_next.day = (int_reg.day == 8'h07) ? 8'h01
                                                 : bcd_inc(int_reg.day);
          if (int_reg.date != month_end(int_reg.month, int_reg.year)) begin
            int_next.date = bcd_inc(int_reg.date);
          end else begin
            int_next.date = 8'h01;
            if (int_reg.month != 8'h12) begin
              int_next.month = bcd_inc(int_reg.month);
            end else begin
              int_next.month = 8'h01;
              if (int_reg.year != 8'h99) begin
                int_next.year = bcd_inc(int_reg.year);
              end else begin
                int_next.year = 8'h00;
                int_next.cent = (int_reg.cent == 8'h39) ? 8'h00
                                : bcd_inc(int_reg.cent);
              end
            end
          end
        end
      end
    end
  end

  // Counts regardless of hold bits or supply; load on write-bit clear
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      int_reg <= '{sec: 8'h00, day: 8'h01, date: 8'h01, month: 8'h01,
                   default: 8'h00};
      whold_prev_reg <= 1'b0;
    end else begin
      whold_prev_reg <= ext_reg[IDX_CTRL][CTRL_WHOLD];
      if (whold_fall) begin
        int_reg <= ext_time;
      end else if (sec_tick && osc_run) begin
        int_reg <= int_next;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // External set and read-hold settle

  logic [14:0] rsettle_reg; // Cycles left before updates resume
  logic upd_ok; // External set may follow internal
  logic host_wr_top; // Host commit into a clock byte

  assign upd_ok = !ext_reg[IDX_CTRL][CTRL_WHOLD] &&
                  !ext_reg[IDX_CTRL][CTRL_RHOLD] && rsettle_reg == '0;
  assign host_wr_top = wr_end && waddr_reg >= TOP_BASE;

  // Read bit must stay low for the settle time first
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      rsettle_reg <= '0;
    end else if (ext_reg[IDX_CTRL][CTRL_RHOLD]) begin
      rsettle_reg <= 15'(RHOLD_CNT);
    end else if (rsettle_reg != '0) begin
      rsettle_reg <= rsettle_reg - 15'h0001;
    end
  end

  // Host writes win; otherwise copy the counting set when allowed
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      for (int i = 0; i < 16; i++) begin
        ext_reg[i] <= BYTE_RESET;
      end
      ext_reg[IDX_SEC] <= SEC_RESET;
      ext_reg[IDX_DAY] <= 8'h01;
      ext_reg[IDX_DATE] <= 8'h01;
      ext_reg[IDX_MONTH] <= 8'h01;
    end else if (host_wr_top) begin
      if (waddr_reg[3:0] != IDX_FLAGS) begin
        ext_reg[waddr_reg[3:0]] <= wdata_reg;
      end
    end else if (upd_ok) begin
      // Spare bits of each byte are kept, only counts follow
      ext_reg[IDX_SEC][6:0] <= int_reg.sec[6:0];
      ext_reg[IDX_MIN][6:0] <= int_reg.min[6:0];
      ext_reg[IDX_HOUR][5:0] <= int_reg.hour[5:0];
      ext_reg[IDX_DAY][2:0] <= int_reg.day[2:0];
      ext_reg[IDX_DATE][5:0] <= int_reg.date[5:0];
      ext_reg[IDX_MONTH][4:0] <= int_reg.month[4:0];
      ext_reg[IDX_YEAR] <= int_reg.year;
      ext_reg[IDX_CTRL][5:0] <= int_reg.cent[5:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Alarm

  logic alm_hit; // Masked compare matches this second
  logic flags_rd; // Host has just started reading flags

  assign alm_hit = sec_tick && osc_run &&
    (ext_reg[IDX_ALM_SEC][ALM_MASK] ||
     ext_reg[IDX_ALM_SEC][6:0] == int_next.sec[6:0]) &&
    (ext_reg[IDX_ALM_MIN][ALM_MASK] ||
     ext_reg[IDX_ALM_MIN][6:0] == int_next.min[6:0]) &&
    (ext_reg[IDX_ALM_HOUR][ALM_MASK] ||
     ext_reg[IDX_ALM_HOUR][5:0] == int_next.hour[5:0]) &&
    (ext_reg[IDX_ALM_DATE][ALM_MASK] ||
     ext_reg[IDX_ALM_DATE][5:0] == int_next.date[5:0]);
  assign flags_rd = rd_act && !rd_prev_reg && top_sel &&
                    pins_s.addr[3:0] == IDX_FLAGS;

  // Sticky alarm flag; a new match beats the read clear
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      af_reg <= 1'b0;
    end else if (alm_hit) begin
      af_reg <= 1'b1;
    end else if (flags_rd) begin
      af_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Watchdog

  logic [10:0] wd_cnt_reg; // Sixteenths since last kick
  logic [10:0] wd_limit; // Programmed interval in sixteenths
  logic wd_fire; // Interval expired this cycle
  logic wd_kick; // Host rewrote the watchdog byte

  // Resolution scales the multiplier: 1/16, 1/4, 1 or 4 seconds
  always_comb begin
    case (ext_reg[IDX_WDOG][1:0])
      2'h0: wd_limit = {6'h00, ext_reg[IDX_WDOG][6:2]};
      2'h1: wd_limit = {4'h0, ext_reg[IDX_WDOG][6:2], 2'h0};
      2'h2: wd_limit = {2'h0, ext_reg[IDX_WDOG][6:2], 4'h0};
      default: wd_limit = {ext_reg[IDX_WDOG][6:2], 6'h00};
    endcase
  end

  assign wd_kick = host_wr_top && waddr_reg[3:0] == IDX_WDOG;
  assign wd_fire = sixt_tick && wd_limit != '0 &&
                   wd_cnt_reg + 11'h001 >= wd_limit;

  // Zero multiplier disables; each host write of the watchdog byte restarts the interval
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      wd_cnt_reg <= '0;
    end else if (wd_kick || wd_fire) begin
      wd_cnt_reg <= '0;
    end else if (sixt_tick && wd_limit != '0) begin
      wd_cnt_reg <= wd_cnt_reg + 11'h001;
    end
  end

  // Sticky watchdog flag; expiry beats the read clear
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      wf_reg <= 1'b0;
    end else if (wd_fire) begin
      wf_reg <= 1'b1;
    end else if (flags_rd) begin
      wf_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Interrupt and reset pins

  logic [21:0] rst_cnt_reg; // Stretch cycles left
  logic wd_rst; // Watchdog steered to reset

  assign wd_rst = wd_fire && ext_reg[IDX_WDOG][WDOG_STEER];
  assign alarm_wake_out_n = 1'b0;
  assign reset_out_n = 1'b0;

  // Alarm needs the enable, and on battery also the wake enable
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      alarm_wake_oe <= 1'b0;
    end else begin
      alarm_wake_oe <= (af_reg && ext_reg[IDX_INTR][INTR_AE] &&
                        (pins_s.pwr_ok ||
                         ext_reg[IDX_INTR][INTR_ABE])) ||
                       (wf_reg && !ext_reg[IDX_WDOG][WDOG_STEER]);
    end
  end

  // Held while supply is low, then stretched; watchdog reuses it
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      rst_cnt_reg <= 22'(RST_CNT);
      reset_oe <= 1'b1;
    end else if (!pins_s.pwr_ok || wd_rst) begin
      rst_cnt_reg <= 22'(RST_CNT);
      reset_oe <= 1'b1;
    end else if (rst_cnt_reg != '0) begin
      rst_cnt_reg <= rst_cnt_reg - 22'h000001;
      reset_oe <= 1'b1;
    end else begin
      reset_oe <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks

  a_write_no_drive: assert property (
    @(posedge mclk) disable iff (!resetn)
    wr_act |=> !data_lines_oe)
    else $error("data driven during a write");

  a_strobe_release: assert property (
    @(posedge mclk) disable iff (!resetn)
    rd_act && !pins_s.oe_n ##1 !pins_s.we_n && !pins_s.cs_n
    |=> !data_lines_oe)
    else $error("read drive not released on write strobe");

  a_drive_cause: assert property (
    @(posedge mclk) disable iff (!resetn)
    data_lines_oe |-> $past(!pins_s.cs_n && !pins_s.oe_n && pins_s.we_n))
    else $error("data driven without both enables");

  a_pf_blocks: assert property (
    @(posedge mclk) disable iff (!resetn)
    !pins_s.pwr_ok |=> !data_lines_oe && !wr_prev_reg)
    else $error("access while below power-fail level");

  a_ram_store: assert property (
    @(posedge mclk) disable iff (!resetn)
    wr_end && waddr_reg < TOP_BASE |=> mem[$past(waddr_reg)] ==
    $past(wdata_reg))
    else $error("write data not stored");

  a_reset_stretch: assert property (
    @(posedge mclk) disable iff (!resetn)
    $rose(pins_s.pwr_ok) |-> reset_oe [*8])
    else $error("reset released early after supply return");

  a_reset_lowsup: assert property (
    @(posedge mclk) disable iff (!resetn)
    !pins_s.pwr_ok |=> reset_oe)
    else $error("reset not active while supply low");

  a_hold_freeze: assert property (
    @(posedge mclk) disable iff (!resetn)
    ext_reg[IDX_CTRL][CTRL_RHOLD] && !host_wr_top
    |=> $stable(ext_reg[IDX_MIN]) && $stable(ext_reg[IDX_YEAR]))
    else $error("external set moved under read hold");

  a_int_counts: assert property (
    @(posedge mclk) disable iff (!resetn)
    sec_tick && osc_run && !whold_fall |=> int_reg.sec ==
    $past(int_next.sec))
    else $error("internal set did not advance");

  a_whold_load: assert property (
    @(posedge mclk) disable iff (!resetn)
    whold_fall |=> int_reg == $past(ext_time))
    else $error("write hold clear did not load internal set");

  a_alarm_irq: assert property (
    @(posedge mclk) disable iff (!resetn)
    alm_hit && ext_reg[IDX_INTR][INTR_AE] && pins_s.pwr_ok
    ##1 pins_s.pwr_ok |=> alarm_wake_oe)
    else $error("alarm match gave no interrupt");

  a_wdog_fire: assert property (
    @(posedge mclk) disable iff (!resetn)
    wd_fire |=> wf_reg)
    else $error("watchdog expiry not flagged");

endmodule

`default_nettype wire

// ### testbench/nvtk_host_model.sv
// Host CPU model that drives the pins of the timekeeping RAM port.
// Assumes the bench calls its tasks by hierarchy and supplies mclk.
`timescale 1ns/10ps
`default_nettype none
module nvtk_host_model (
  input wire logic mclk, // Bench clock
  output logic cs_n, // Chip select
  output logic oe_n, // Output enable
  output logic we_n, // Write strobe
  output logic [14:0] addr, // Address lines
  output logic [7:0] bus, // Resolved data lines
  input wire logic [7:0] dev_d, // Device data value
  input wire logic dev_oe // Device drives data
);
  logic [7:0] hd = 8'h00; // Host write data
  logic hoe = 1'h0; // Host drives data
  logic ph = 1'h0; // Float pattern phase
  initial begin
    cs_n = 1'h1;
    oe_n = 1'h1;
    we_n = 1'h1;
    addr = 15'h0000;
  end
  always @(posedge mclk) ph <= ~ph;
  // Floating bus toggles, so stale data can never look valid
  assign bus = dev_oe ? dev_d : hoe ? hd : {8{ph}} ^ 8'h5A;
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  // Address and data held past the synced end of the strobe
  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    cyc(1);
    addr = a;
    hd = d;
    hoe = 1'h1;
    cs_n = 1'h0;
    we_n = 1'h0;
    cyc(4);
    we_n = 1'h1;
    cs_n = 1'h1;
    cyc(3);
    hoe = 1'h0;
    cyc(1);
  endtask
  task automatic rd(input logic [14:0] a, input logic oe,
                    output logic [7:0] d, output logic doe);
    cyc(1);
    addr = a;
    cs_n = 1'h0;
    oe_n = ~oe;
    cyc(5);
    d = bus;
    doe = dev_oe;
    cs_n = 1'h1;
    oe_n = 1'h1;
    cyc(3);
  endtask
endmodule
`default_nettype wire

// ### testbench/nvtk_host_port_tb.sv
// Self-checking bench of the timekeeping RAM host port.
// Assumes short counts: 4 cycles per sixteenth, 10-cycle reset stretch.
`timescale 1ns/10ps
`default_nettype none
module nvtk_host_port_tb;
  import nvtk_pkg::*;
  logic mclk = 1'h0; // 40 MHz clock
  logic resetn = 1'h0; // Reset, active low
  logic supply_ok = 1'h1; // Supply good
  logic cs_n, oe_n, we_n, doe, a_oe, r_oe, v;
  logic irq_v, rst_v; // Open-drain pin values
  logic [14:0] addr;
  logic [7:0] din, dout, d, d2;
  int n_errors = 0;
  int n_checks = 0;
  always #12.5 mclk = ~mclk;
  nvtk_host_model host (.mclk(mclk), .cs_n(cs_n), .oe_n(oe_n),
    .we_n(we_n), .addr(addr), .bus(din), .dev_d(dout), .dev_oe(doe));
  nvtk_host_port #(.SIXT_CNT(4), .RHOLD_CNT(5), .RST_CNT(10)) uut (
    .mclk(mclk), .resetn(resetn), .chip_sel_n(cs_n), .out_en_n(oe_n),
    .write_n(we_n), .address_lines(addr), .data_lines_in(din),
    .supply_ok(supply_ok), .data_lines_out(dout), .data_lines_oe(doe),
    .alarm_wake_out_n(irq_v), .alarm_wake_oe(a_oe), .reset_out_n(rst_v),
    .reset_oe(r_oe));
  task automatic chk(input string nm, input logic [7:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic results;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Reset stretch, then bytes at both array ends, back to back
  task automatic t_ram;
    host.cyc(3);
    chk("rst_stretch", r_oe, 1'h1);
    chk("idle_oe", doe, 1'h0);
    host.cyc(12);
    chk("rst_done", r_oe, 1'h0);
    host.wr(15'h0000, 8'h3C);
    host.wr(15'h7FEF, 8'hC3);
    host.rd(15'h0000, 1'h1, d, v);
    chk("ram_lo", d, 8'h3C);
    host.rd(15'h7FEF, 1'h1, d, v);
    chk("ram_hi", d, 8'hC3);
    host.rd(15'h7FEF, 1'h0, d, v);
    chk("rd_oe_high", v, 1'h0);
  endtask
  // Output enable low before the strobe falls
  task automatic t_wr_oe;
    host.cs_n = 1'h0;
    host.oe_n = 1'h0;
    host.addr = 15'h0001;
    host.cyc(5);
    chk("pre_drive", doe, 1'h1);
    host.we_n = 1'h0;
    host.hd = 8'h96;
    host.hoe = 1'h1;
    host.cyc(4);
    chk("wr_release", doe, 1'h0);
    host.we_n = 1'h1;
    host.cs_n = 1'h1;
    host.oe_n = 1'h1;
    host.cyc(3);
    host.hoe = 1'h0;
    host.rd(15'h0001, 1'h1, d, v);
    chk("wr_oe_data", d, 8'h96);
  endtask
  // Supply loss blocks access and holds reset
  task automatic t_pwr;
    supply_ok = 1'h0;
    host.cyc(4);
    host.wr(15'h0000, 8'hFF);
    host.rd(15'h0000, 1'h1, d, v);
    chk("pf_drive", v, 1'h0);
    chk("pf_reset", r_oe, 1'h1);
    supply_ok = 1'h1;
    host.cyc(16);
    chk("pf_reset_end", r_oe, 1'h0);
    host.rd(15'h0000, 1'h1, d, v);
    chk("pf_kept", d, 8'h3C);
  endtask
  // Load 23:59:59, count past midnight, freeze and read
  task automatic t_clock;
    host.wr(15'h7FF8, 8'h80);
    host.wr(15'h7FF9, 8'h59);
    host.wr(15'h7FFA, 8'h59);
    host.wr(15'h7FFB, 8'h23);
    host.wr(15'h7FF8, 8'h00);
    host.cyc(100);
    host.wr(15'h7FF8, 8'h40);
    host.rd(15'h7FFB, 1'h1, d, v);
    chk("hour_wrap", d, 8'h00);
    host.rd(15'h7FFA, 1'h1, d, v);
    chk("min_wrap", d, 8'h00);
    host.rd(15'h7FFD, 1'h1, d, v);
    chk("date_next", d, 8'h02);
    host.rd(15'h7FF9, 1'h1, d, v);
    host.cyc(70);
    host.rd(15'h7FF9, 1'h1, d2, v);
    chk("hold_sec", d2, d);
  endtask
  // Watchdog to interrupt, cleared by a flags read, then steered to reset
  task automatic t_wdog;
    host.wr(15'h7FF7, 8'h04);
    host.cyc(8);
    chk("wd_irq", a_oe, 1'h1);
    host.wr(15'h7FF7, 8'h00);
    host.rd(15'h7FF0, 1'h1, d, v);
    chk("flag_clear", d, 8'h00);
    chk("wd_irq_end", a_oe, 1'h0);
    host.wr(15'h7FF7, 8'h84);
    host.cyc(8);
    chk("wd_reset", r_oe, 1'h1);
    host.wr(15'h7FF7, 8'h00);
    host.rd(15'h7FF0, 1'h1, d, v);
    host.cyc(8);
    chk("wd_reset_end", r_oe, 1'h0);
  endtask
  // Every-second alarm; on battery it needs the wake enable
  task automatic t_alarm;
    host.wr(15'h7FF2, 8'h80);
    host.wr(15'h7FF3, 8'h80);
    host.wr(15'h7FF4, 8'h80);
    host.wr(15'h7FF5, 8'h80);
    host.wr(15'h7FF6, 8'h80);
    host.cyc(70);
    chk("alarm_irq", a_oe, 1'h1);
    chk("irq_level", irq_v, 1'h0);
    supply_ok = 1'h0;
    host.cyc(4);
    chk("alarm_batt_off", a_oe, 1'h0);
    supply_ok = 1'h1;
    host.cyc(16);
    host.wr(15'h7FF6, 8'hA0);
    supply_ok = 1'h0;
    host.cyc(4);
    chk("alarm_batt_on", a_oe, 1'h1);
    chk("rst_level", rst_v, 1'h0);
    supply_ok = 1'h1;
    host.cyc(16);
  endtask
  initial begin
    repeat (20) @(posedge mclk);
    #1 resetn = 1'h1;
    t_ram();
    t_wr_oe();
    t_pwr();
    t_clock();
    t_wdog();
    t_alarm();
    results();
  end
  // Hang guard, far past the few hundred cycles the tests need
  initial begin
    #100000;
    n_errors++;
    results();
  end
endmodule
`default_nettype wire
